// ---- rtl/baud_pkg.sv ----
// Constants, divisor table and register map of the dual rate generator.
// Assumes one 50 MHz system clock; all pins are asynchronous to it.
package baud_pkg;

    localparam int SEL_W = 4;
    localparam int DIV_W = 15;
    localparam int NUM_RATES = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CFG_W = 4;
    localparam int PIN_W = 16;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_MIN_NS = 150;
    localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NOMINAL_IN_HZ = 5068800;
    localparam int SWITCH_MAX_PERIODS = 18;

    // Default divisor table for a 5.0688 MHz master, sixteen-times clocks
    localparam logic [DIV_W-1:0] DIV_ROM [NUM_RATES] = '{
        15'h18C0, 15'h1080, 15'h0B40, 15'h0933,
        15'h0840, 15'h0420, 15'h0210, 15'h0108,
        15'h00B0, 15'h009E, 15'h0084, 15'h0058,
        15'h0042, 15'h002C, 15'h0021, 15'h0010
    };
    localparam logic [DIV_W-1:0] DIV_RESET = DIV_ROM[0];
    localparam logic [SEL_W-1:0] CODE_RESET = 4'h0;

    // Synchronised pin vector layout
    localparam int PIN_MCLK = 15;
    localparam int PIN_RXSEL = 11;
    localparam int PIN_RXSTB = 10;
    localparam int PIN_TXSEL = 6;
    localparam int PIN_TXSTB = 5;
    localparam int PIN_SEL = 1;
    localparam int PIN_STB = 0;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RX_DIV = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TX_DIV = 8'h0C;

    // Config fields
    localparam int CFG_SINGLE = 0;
    localparam int CFG_REF_EN = 1;
    localparam int CFG_RX_EN = 2;
    localparam int CFG_TX_EN = 3;
    localparam logic [CFG_W-1:0] CFG_RESET = 4'hE;

    // Status fields
    localparam int STAT_RX_CODE = 0;
    localparam int STAT_TX_CODE = 4;
    localparam int STAT_RX_STB = 8;
    localparam int STAT_TX_STB = 9;
    localparam int STAT_STB = 10;
    localparam int STAT_RX_OUT = 11;
    localparam int STAT_TX_OUT = 12;
    localparam int STAT_REF_OUT = 13;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    function automatic logic [DIV_W-1:0] rom_divisor(input logic [SEL_W-1:0] code);
        return DIV_ROM[code];
    endfunction

    function automatic logic [DIV_W-1:0] high_count(input logic [DIV_W-1:0] div);
        return div >> 1;
    endfunction

endpackage

// ---- rtl/baud_rate_gen.sv ----
// Dual baud rate generator: two rate dividers, quarter reference, AXI4-Lite regs.
// Assumes all pins are asynchronous to clk_in and the master clock is slower
// than a quarter of clk_in so every edge is seen after synchronising.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module baud_rate_gen (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic master_clock_in_a_in,
    input wire logic [baud_pkg::SEL_W-1:0] rx_sel_in,
    input wire logic rx_select_latch_pulse_in,
    input wire logic [baud_pkg::SEL_W-1:0] tx_sel_in,
    input wire logic tx_select_latch_pulse_in,
    input wire logic [baud_pkg::SEL_W-1:0] sel_in,
    input wire logic select_latch_pulse_in,
    output logic rx_rate_out,
    output logic tx_rate_out,
    output logic single_rate_out,
    output logic ref_clock_out,
    input wire logic [baud_pkg::ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [baud_pkg::DATA_W-1:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [baud_pkg::ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [baud_pkg::DATA_W-1:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in
);
    import baud_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] pins_meta;
        logic [PIN_W-1:0] pins_sync;
        logic mclk_prev;
        logic [SEL_W-1:0] rx_code;
        logic [SEL_W-1:0] tx_code;
        logic [CFG_W-1:0] cfg;
        logic [1:0] ref_cnt;
        logic rx_rate;
        logic tx_rate;
        logic single_rate;
        logic ref_clk;
        logic aw_rdy;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_rdy;
        logic w_have;
        logic [DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } top_state_type;

    top_state_type st_r;
    top_state_type st_nxt;

    // Reset image: codes at zero, config at its default, bus idle
    localparam top_state_type RESET_STATE = '{
        pins_meta: '0,
        pins_sync: '0,
        mclk_prev: 1'b0,
        rx_code: CODE_RESET,
        tx_code: CODE_RESET,
        cfg: CFG_RESET,
        ref_cnt: '0,
        rx_rate: 1'b0,
        tx_rate: 1'b0,
        single_rate: 1'b0,
        ref_clk: 1'b0,
        aw_rdy: 1'b0,
        aw_have: 1'b0,
        aw_addr: '0,
        w_rdy: 1'b0,
        w_have: 1'b0,
        w_data: '0,
        w_strb: '0,
        bvalid: 1'b0,
        bresp: '0,
        ar_rdy: 1'b0,
        rvalid: 1'b0,
        rdata: '0,
        rresp: '0
    };

    rate_if rx_link ();
    rate_if tx_link ();

    logic [PIN_W-1:0] pins_raw;
    logic mclk_tick;

    assign pins_raw = {master_clock_in_a_in, rx_sel_in, rx_select_latch_pulse_in,
                       tx_sel_in, tx_select_latch_pulse_in, sel_in, select_latch_pulse_in};

    // One pulse per master clock rising edge, seen after synchronising
    assign mclk_tick = st_r.pins_sync[PIN_MCLK] & ~st_r.mclk_prev;

    assign rx_link.tick = mclk_tick;
    assign rx_link.code = st_r.rx_code;
    assign tx_link.tick = mclk_tick;
    assign tx_link.code = st_r.tx_code;

    rate_divider rx_divider (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .port_io(rx_link.core)
    );

    rate_divider tx_divider (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .port_io(tx_link.core)
    );

    function automatic logic [ADDR_W-3:0] word_of(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction

    typedef enum logic [2:0] {
        HIT_CONFIG = 3'b000,
        HIT_STATUS = 3'b001,
        HIT_RX_DIV = 3'b010,
        HIT_TX_DIV = 3'b011,
        HIT_NONE = 3'b100
    } reg_hit_type;

    // Shared by the read and write channels
    function automatic reg_hit_type decode_reg(input logic [ADDR_W-1:0] addr);
        reg_hit_type hit;
        if (word_of(addr) == word_of(REG_CONFIG)) begin
            hit = HIT_CONFIG;
        end else if (word_of(addr) == word_of(REG_STATUS)) begin
            hit = HIT_STATUS;
        end else if (word_of(addr) == word_of(REG_RX_DIV)) begin
            hit = HIT_RX_DIV;
        end else if (word_of(addr) == word_of(REG_TX_DIV)) begin
            hit = HIT_TX_DIV;
        end else begin
            hit = HIT_NONE;
        end
        return hit;
    endfunction

    always_comb begin
        logic single;
        logic [DATA_W-1:0] status;
        reg_hit_type ar_hit;
        reg_hit_type aw_hit;
        single = st_r.cfg[CFG_SINGLE];
        status = '0;
        ar_hit = decode_reg(araddr_in);
        aw_hit = decode_reg(st_r.aw_addr);
        st_nxt = st_r;

        // Two-flop synchronisers for every pin
        st_nxt.pins_meta = pins_raw;
        st_nxt.pins_sync = st_r.pins_meta;
        st_nxt.mclk_prev = st_r.pins_sync[PIN_MCLK];

        // Level-sensitive select latches
        if (single) begin
            if (st_r.pins_sync[PIN_STB]) begin
                st_nxt.rx_code = st_r.pins_sync[PIN_SEL +: SEL_W];
            end
        end else begin
            if (st_r.pins_sync[PIN_RXSTB]) begin
                st_nxt.rx_code = st_r.pins_sync[PIN_RXSEL +: SEL_W];
            end
            if (st_r.pins_sync[PIN_TXSTB]) begin
                st_nxt.tx_code = st_r.pins_sync[PIN_TXSEL +: SEL_W];
            end
        end

        // Quarter rate reference
        if (mclk_tick) begin
            st_nxt.ref_cnt = st_r.ref_cnt + 2'h1;
        end
        st_nxt.ref_clk = st_r.cfg[CFG_REF_EN] & st_nxt.ref_cnt[1];

        // Output stage
        st_nxt.rx_rate = st_r.cfg[CFG_RX_EN] & ~single & rx_link.out;
        st_nxt.tx_rate = st_r.cfg[CFG_TX_EN] & ~single & tx_link.out;
        st_nxt.single_rate = single & rx_link.out;

        // Write address and data taken in either order
        if (awvalid_in && st_r.aw_rdy) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = awaddr_in;
            st_nxt.aw_rdy = 1'b0;
        end else if (!st_r.aw_have && !st_r.bvalid) begin
            st_nxt.aw_rdy = 1'b1;
        end
        if (wvalid_in && st_r.w_rdy) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = wdata_in;
            st_nxt.w_strb = wstrb_in;
            st_nxt.w_rdy = 1'b0;
        end else if (!st_r.w_have && !st_r.bvalid) begin
            st_nxt.w_rdy = 1'b1;
        end

        if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            if (aw_hit == HIT_CONFIG) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.cfg = st_r.w_data[CFG_W-1:0];
                end
                st_nxt.bresp = RESP_OKAY;
            end else if (aw_hit == HIT_STATUS) begin
                st_nxt.bresp = RESP_SLVERR;
            end else if (aw_hit == HIT_RX_DIV) begin
                st_nxt.bresp = RESP_SLVERR;
            end else if (aw_hit == HIT_TX_DIV) begin
                st_nxt.bresp = RESP_SLVERR;
            end else begin
                st_nxt.bresp = RESP_DECERR;
            end
        end else if (st_r.bvalid && bready_in) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel
        status[STAT_RX_CODE +: SEL_W] = st_r.rx_code;
        status[STAT_TX_CODE +: SEL_W] = st_r.tx_code;
        status[STAT_RX_STB] = st_r.pins_sync[PIN_RXSTB];
        status[STAT_TX_STB] = st_r.pins_sync[PIN_TXSTB];
        status[STAT_STB] = st_r.pins_sync[PIN_STB];
        status[STAT_RX_OUT] = rx_link.out;
        status[STAT_TX_OUT] = tx_link.out;
        status[STAT_REF_OUT] = st_r.ref_clk;

        if (arvalid_in && st_r.ar_rdy) begin
            st_nxt.ar_rdy = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            if (ar_hit == HIT_CONFIG) begin
                st_nxt.rdata = {{(DATA_W-CFG_W){1'b0}}, st_r.cfg};
            end else if (ar_hit == HIT_STATUS) begin
                st_nxt.rdata = status;
            end else if (ar_hit == HIT_RX_DIV) begin
                st_nxt.rdata = {{(DATA_W-DIV_W){1'b0}}, rx_link.divisor};
            end else if (ar_hit == HIT_TX_DIV) begin
                st_nxt.rdata = {{(DATA_W-DIV_W){1'b0}}, tx_link.divisor};
            end else begin
                st_nxt.rdata = '0;
                st_nxt.rresp = RESP_DECERR;
            end
        end else if (st_r.rvalid && rready_in) begin
            st_nxt.rvalid = 1'b0;
        end else if (!st_r.rvalid) begin
            st_nxt.ar_rdy = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_r <= RESET_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rx_rate_out = st_r.rx_rate;
    assign tx_rate_out = st_r.tx_rate;
    assign single_rate_out = st_r.single_rate;
    assign ref_clock_out = st_r.ref_clk;
    assign awready_out = st_r.aw_rdy;
    assign wready_out = st_r.w_rdy;
    assign bvalid_out = st_r.bvalid;
    assign bresp_out = st_r.bresp;
    assign arready_out = st_r.ar_rdy;
    assign rvalid_out = st_r.rvalid;
    assign rdata_out = st_r.rdata;
    assign rresp_out = st_r.rresp;

endmodule
`default_nettype wire

// ---- rtl/rate_divider.sv ----
// One programmable rate divider counting master clock ticks.
// Assumes tick is a one-cycle pulse per master clock rising edge.
`timescale 1ns/10ps
`default_nettype none
module rate_divider (
    input wire logic clk_in,
    input wire logic rst_b_in,
    rate_if.core port_io
);
    import baud_pkg::*;

    typedef struct packed {
        logic [SEL_W-1:0] code;
        logic [DIV_W-1:0] div;
        logic [DIV_W-1:0] cnt;
        logic out;
    } div_state_type;

    div_state_type st_r;
    div_state_type st_nxt;

    always_comb begin
        logic [DIV_W-1:0] new_div;
        logic [DIV_W-1:0] cnt_next;
        new_div = rom_divisor(port_io.code);
        cnt_next = '0;
        st_nxt = st_r;
        if (port_io.code != st_r.code) begin
            // Restart at once on a new code
            st_nxt.code = port_io.code;
            st_nxt.div = new_div;
            st_nxt.cnt = '0;
            st_nxt.out = (high_count(new_div) != '0);
        end else if (port_io.tick) begin
            // Modulus up to 2^15-1
            if (st_r.cnt >= st_r.div - 15'h0001) begin
                cnt_next = '0;
            end else begin
                cnt_next = st_r.cnt + 15'h0001;
            end
            st_nxt.cnt = cnt_next;
            st_nxt.out = (cnt_next < high_count(st_r.div));
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_r <= '{code: CODE_RESET, div: DIV_RESET, cnt: '0, out: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port_io.out = st_r.out;
    assign port_io.divisor = st_r.div;

endmodule
`default_nettype wire

// ---- rtl/rate_if.sv ----
// Carrier between the top and one rate divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface rate_if;
    import baud_pkg::*;
    logic tick;
    logic [SEL_W-1:0] code;
    logic out;
    logic [DIV_W-1:0] divisor;
    modport core (input tick, input code, output out, output divisor);
    modport ctrl (output tick, output code, input out, input divisor);
endinterface
`default_nettype wire

// ---- verification/baud_rate_gen_asserts.sv ----
// Port checker for the dual rate generator.
// Assumes synchronous active-low reset and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module baud_rate_gen_asserts (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic rx_rate_out,
    input wire logic tx_rate_out,
    input wire logic single_rate_out,
    input wire logic awvalid_in,
    input wire logic awready_out,
    input wire logic wvalid_in,
    input wire logic wready_out,
    input wire logic [1:0] bresp_out,
    input wire logic bvalid_out,
    input wire logic bready_in,
    input wire logic arvalid_in,
    input wire logic arready_out,
    input wire logic [baud_pkg::DATA_W-1:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic rready_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b_in |=>
        !rx_rate_out && !tx_rate_out && !single_rate_out && !bvalid_out)
        else $error("outputs not quiet after reset");
    a_one_mode: assert property (single_rate_out |-> !rx_rate_out && !tx_rate_out)
        else $error("dual outputs active in single mode");
    a_write_answer: assert property (awvalid_in && awready_out && wvalid_in && wready_out
        |=> ##1 bvalid_out) else $error("write response not two cycles after take");
    a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out)
        else $error("read data not one cycle after take");
    a_bvalid_hold: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("write response dropped early");
    a_rvalid_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
        else $error("read data dropped early");
    a_write_reopen: assert property (bvalid_out && bready_in |=>
        !bvalid_out ##[1:2] awready_out && wready_out) else $error("write channel not reopened");
    a_read_reopen: assert property (rvalid_out && rready_in |=> !rvalid_out ##[1:2] arready_out)
        else $error("read channel not reopened");
endmodule
bind baud_rate_gen baud_rate_gen_asserts baud_rate_gen_asserts_inst (.clk_in, .rst_b_in,
    .rx_rate_out, .tx_rate_out, .single_rate_out, .awvalid_in, .awready_out, .wvalid_in,
    .wready_out, .bresp_out, .bvalid_out, .bready_in, .arvalid_in, .arready_out, .rdata_out,
    .rvalid_out, .rready_in);
`default_nettype wire

// ---- verification/baud_rate_gen_bench.sv ----
// Bench for the dual rate generator: register tasks, select pin tasks.
// Assumes a 50 MHz clk_in and a master clock of six clk_in cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module baud_rate_gen_bench;
    import baud_pkg::*;
    localparam int MP = 6;
    logic clk_in = 1'b0, rst_b_in = 1'b0, master_clock_in_a_in = 1'b0;
    logic [3:0] rx_sel_in = 4'h0, tx_sel_in = 4'h0, sel_in = 4'h0, wstrb_in = 4'hF;
    logic rx_select_latch_pulse_in = 1'b0, tx_select_latch_pulse_in = 1'b0;
    logic select_latch_pulse_in = 1'b0, awvalid_in = 1'b0, wvalid_in = 1'b0;
    logic bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
    logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, v;
    logic rx_rate_out, tx_rate_out, single_rate_out, ref_clock_out;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic [1:0] bresp_out, rresp_out;
    logic [3:0] rates;
    logic [15:0] hi[4], lo[4];
    int failures = 0, checked = 0, mcnt = 0;
    always #10 clk_in = ~clk_in;
    // Master clock: three cycles high, three low
    always @(posedge clk_in) begin
        mcnt <= (mcnt == MP - 1) ? 0 : mcnt + 1;
        master_clock_in_a_in <= (mcnt < MP / 2);
    end
    baud_rate_gen baud_rate_gen_inst (.clk_in, .rst_b_in, .master_clock_in_a_in, .rx_sel_in,
        .rx_select_latch_pulse_in, .tx_sel_in, .tx_select_latch_pulse_in, .sel_in,
        .select_latch_pulse_in, .rx_rate_out, .tx_rate_out, .single_rate_out, .ref_clock_out,
        .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out,
        .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out,
        .rdata_out, .rresp_out, .rvalid_out, .rready_in);
    assign rates = {ref_clock_out, single_rate_out, tx_rate_out, rx_rate_out};
    for (genvar i = 0; i < 4; i++) begin : meas
        rate_partner rate_partner_inst (.clk_in, .rate_in(rates[i]), .hi_len_out(hi[i]),
            .lo_len_out(lo[i]));
    end
    // Ready raised with the request; answer taken at the edge it is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr_in <= a;
        wdata_in <= d;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awready_out === 1'b1) awvalid_in <= 1'b0;
            if (wready_out === 1'b1) wvalid_in <= 1'b0;
        end while (bvalid_out !== 1'b1);
        bready_in <= 1'b0;
        `CHK("bresp", er, bresp_out)
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        araddr_in <= a;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arready_out === 1'b1) arvalid_in <= 1'b0;
        end while (rvalid_out !== 1'b1);
        rready_in <= 1'b0;
        v = rdata_out;
        `CHK("rresp", er, rresp_out)
        @(posedge clk_in);
    endtask
    task automatic latch(input logic [3:0] rc, input logic [3:0] tc, input logic [3:0] sc);
        rx_sel_in <= rc;
        tx_sel_in <= tc;
        sel_in <= sc;
        rx_select_latch_pulse_in <= 1'b1;
        tx_select_latch_pulse_in <= 1'b1;
        select_latch_pulse_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        rx_select_latch_pulse_in <= 1'b0;
        tx_select_latch_pulse_in <= 1'b0;
        select_latch_pulse_in <= 1'b0;
        repeat (12) @(posedge clk_in);
    endtask
    task automatic divs(input logic [3:0] rc, input logic [3:0] tc);
        rd(REG_RX_DIV, RESP_OKAY);
        `CHK("rx_div", {17'h0, DIV_ROM[rc]}, v)
        rd(REG_TX_DIV, RESP_OKAY);
        `CHK("tx_div", {17'h0, DIV_ROM[tc]}, v)
    endtask
    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge clk_in);
        failures++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rd(REG_CONFIG, RESP_OKAY);
        `CHK("config", 32'h0000000E, v)
        divs(4'h0, 4'h0);
        $display("test reset done");
        wr(REG_STATUS, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'h0, RESP_DECERR);
        rd(8'h10, RESP_DECERR);
        `CHK("unmapped", 32'h0, v)
        $display("test access done");
        for (int c = 0; c < 16; c++) begin
            latch(c[3:0], 4'hF - c[3:0], 4'h0);
            divs(c[3:0], 4'hF - c[3:0]);
        end
        rx_sel_in <= 4'h3;
        tx_sel_in <= 4'h3;
        repeat (12) @(posedge clk_in);
        divs(4'hF, 4'h0);
        rd(REG_STATUS, RESP_OKAY);
        `CHK("codes", 8'h0F, v[7:0])
        $display("test select done");
        rx_select_latch_pulse_in <= 1'b1;
        for (int c = 4; c < 7; c++) begin
            rx_sel_in <= c[3:0];
            repeat (12) @(posedge clk_in);
            divs(c[3:0], 4'h0);
        end
        $display("test follow done");
        latch(4'hF, 4'hE, 4'h0);
        repeat (600) @(posedge clk_in);
        `CHK("rx_hi", 16'(16 / 2 * MP), hi[0])
        `CHK("rx_lo", 16'((16 - 16 / 2) * MP), lo[0])
        `CHK("tx_hi", 16'(33 / 2 * MP), hi[1])
        `CHK("tx_lo", 16'((33 - 33 / 2) * MP), lo[1])
        `CHK("ref_hi", 16'(2 * MP), hi[3])
        `CHK("ref_lo", 16'(2 * MP), lo[3])
        wr(REG_CONFIG, 32'h0000000C, RESP_OKAY);
        repeat (4) @(posedge clk_in);
        `CHK("ref_off", 1'b0, ref_clock_out)
        $display("test rates done");
        wr(REG_CONFIG, 32'h0000000F, RESP_OKAY);
        latch(4'h0, 4'h0, 4'hB);
        repeat (1200) @(posedge clk_in);
        `CHK("single_hi", 16'(88 / 2 * MP), hi[2])
        `CHK("single_lo", 16'((88 - 88 / 2) * MP), lo[2])
        `CHK("rx_muted", 1'b0, rx_rate_out)
        $display("test single done");
        wrap_up;
    end
endmodule
`default_nettype wire

// ---- verification/rate_partner.sv ----
// Serial-side consumer of one rate clock; measures high and low widths.
// Assumes the rate clock is sampled on clk_in and each width fits 16 bits.
`timescale 1ns/10ps
`default_nettype none
module rate_partner (
    input wire logic clk_in,
    input wire logic rate_in,
    output logic [15:0] hi_len_out,
    output logic [15:0] lo_len_out
);
    logic prev_r;
    logic [15:0] run_r;
    // Samples the rate on clk_in and counts each width in clk_in cycles
    always @(posedge clk_in) begin
        prev_r <= rate_in;
        if (rate_in !== prev_r) begin
            run_r <= 16'h0001;
            if (prev_r === 1'b1) hi_len_out <= run_r;
            if (prev_r === 1'b0) lo_len_out <= run_r;
        end else begin
            run_r <= run_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire
